// ### see_pkg.sv
// Purpose: shared constants for the serial memory slave
// Assumes: system clock i_mclk at 40 MHz
// Notes: address width picks the density variant (8, 9, 10 or 11 bits)
package see_pkg;
  // array address width of the largest variant, and the default
  localparam int unsigned FULL_ADDR_W = 11;
  localparam int unsigned ADDR_W_DEF = 11;
  // page buffer: 16 bytes, indexed by the low four address bits
  localparam int unsigned PAGE_W = 4;
  // device-type code; the value is arbitrary
  localparam logic [3:0] DEV_TYPE_DEF = 4'h5;
  // slave address byte field positions
  localparam int unsigned DTYPE_MSB = 7;
  localparam int unsigned DTYPE_LSB = 4;
  localparam int unsigned DHI_MSB = 3;
  localparam int unsigned DHI_LSB = 1;
  localparam int unsigned RW_BIT = 0;
  localparam logic RW_READ = 1'b1;
  // bits in one byte on the wire
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // internal write cycle: longest time, rounded down to clocks
  localparam int unsigned TWR_MS = 10;
  localparam int unsigned MCLK_NS = 25;
  localparam int unsigned NS_PER_MS = 1000000;
  localparam int unsigned TWR_CYC = TWR_MS * NS_PER_MS / MCLK_NS;
endpackage

// ### see_mem_if.sv
// Purpose: carrier between protocol engine and memory array
// Assumes: one clock domain, i_mclk
// Notes: commit is a one-cycle pulse; rdata follows raddr one clock late
`timescale 1ns/100ps
interface see_mem_if #(
  parameter int unsigned ADDR_W = see_pkg::ADDR_W_DEF,
  parameter int unsigned PAGE_W = see_pkg::PAGE_W
);
  logic [ADDR_W-1:0] raddr; // read address (address counter)
  logic [7:0] rdata; // registered read data
  logic buf_we; // store one byte in the page buffer
  logic [PAGE_W-1:0] buf_idx; // page buffer slot
  logic [7:0] buf_data; // byte to buffer
  logic commit; // program buffered bytes into the array
  logic [ADDR_W-PAGE_W-1:0] page; // page being programmed
  logic pending; // at least one byte waits in the buffer
  modport ctl (output raddr, buf_we, buf_idx, buf_data, commit, page,
    input rdata, pending);
  modport mem (input raddr, buf_we, buf_idx, buf_data, commit, page,
    output rdata, pending);
endinterface

// ### see_sync.sv
// Purpose: two-flop synchroniser for a group of pin levels
// Assumes: inputs are levels that change slowly against i_mclk
// Notes: resets to all ones, the idle level of the bus lines
`timescale 1ns/100ps
module see_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);
  logic [WIDTH-1:0] meta_q; // first stage, read only by the second

  // two stages; nothing else looks at meta_q
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_q <= '1;
      o_q <= '1;
    end else begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end
endmodule

// ### see_mem.sv
// Purpose: memory array with a page buffer and masked page commit
// Assumes: commit and buf_we never in the same cycle
// Notes: array contents are not reset, like a real nonvolatile store
`timescale 1ns/100ps
module see_mem #(
  parameter int unsigned ADDR_W = see_pkg::ADDR_W_DEF,
  parameter int unsigned PAGE_W = see_pkg::PAGE_W
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  see_mem_if.mem mif
);
  localparam int unsigned PAGE_BYTES = 2 ** PAGE_W;
  logic [7:0] arr_q [2**ADDR_W]; // the storage array
  logic [7:0] page_q [PAGE_BYTES]; // bytes waiting for programming
  logic [PAGE_BYTES-1:0] valid_q; // which slots hold a new byte
  logic [7:0] rdata_q; // registered read port

  assign mif.rdata = rdata_q;
  assign mif.pending = |valid_q;

  // read port, one clock of latency
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= arr_q[mif.raddr];
    end
  end

  // page buffer; a later byte to the same slot replaces the earlier
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      valid_q <= '0;
    end else if (mif.commit) begin
      valid_q <= '0;
    end else if (mif.buf_we) begin
      valid_q[mif.buf_idx] <= 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (mif.buf_we) begin
      page_q[mif.buf_idx] <= mif.buf_data;
    end
  end

  // all buffered bytes go in together; untouched slots keep old data
  always_ff @(posedge i_mclk) begin
    if (mif.commit) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (valid_q[i]) begin
          arr_q[{mif.page, PAGE_W'(i)}] <= page_q[i];
        end
      end
    end
  end
endmodule

// ### see_top.sv
// Purpose: two-wire serial slave for a byte-addressed memory array
// Assumes: bus lines synchronised to i_mclk; bus clock far below i_mclk
// Notes: sda is open drain; o_sda_oe high pulls the line low
//
// Overview of operation
// - ignore transaction unless type code matches
// - next three address bits give high address
// - last address bit: one read, zero write
// - acknowledge own address, then read or write
// - receiver pulls data low in ninth clock
// - acknowledge word address and each data byte
// - read: send byte, release, continue on ack
// - after write stop, ignore bus until done
// - page write increments only low address bits
// - over sixteen bytes wrap and overwrite in page
// - stop commits buffered bytes in one cycle
// - polling: no acknowledge while write cycle runs
// - write protect: no data acknowledge, no programming
// - counter holds last address plus one, wraps
// - sequential read advances whole counter, wraps
// - start and stop seen while clock high
// - write cycle lasts at most ten milliseconds
`timescale 1ns/100ps
module see_top #(
  parameter int unsigned ADDR_W = see_pkg::ADDR_W_DEF,
  parameter logic [3:0] DEV_TYPE = see_pkg::DEV_TYPE_DEF,
  parameter int unsigned TWR_CYCLES = see_pkg::TWR_CYC
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_wp,
  output logic o_sda_o,
  output logic o_sda_oe,
  output logic o_busy
);
  localparam int unsigned PAGE_W = see_pkg::PAGE_W;
  localparam int unsigned CW = $clog2(TWR_CYCLES + 1);

  typedef enum logic [2:0] {
    S_IDLE, S_DEV, S_WADDR, S_WDATA, S_ACK, S_TX, S_RACK, S_IGNORE
  } see_state_t;

  see_state_t state_q; // protocol state
  see_state_t ret_q; // state to resume after an acknowledge
  logic [2:0] pins_s; // synchronised {wp, scl, sda}
  logic scl_s; // synchronised clock line
  logic sda_s; // synchronised data line
  logic wp_s; // synchronised write protect
  logic scl_p_q; // clock line one cycle ago
  logic sda_p_q; // data line one cycle ago
  logic scl_rise;
  logic scl_fall;
  logic start_det; // data falls while clock high
  logic stop_det; // data rises while clock high
  logic bus_start; // start seen while the bus interface is enabled
  logic bus_stop; // stop seen while the bus interface is enabled
  logic [3:0] bits_q; // bits shifted in or out of the current byte
  logic byte_end; // falling clock after the eighth bit
  logic [7:0] shreg_q; // receive shift register
  logic [2:0] dev_hi_q; // high address bits from the slave address
  logic type_ok; // received type code is ours
  logic ack_now; // this byte earns an acknowledge
  logic wr_accept; // a data byte goes into the page buffer
  logic load_byte; // start sending a fresh byte
  logic mack_q; // master acknowledged the byte just sent
  logic [7:0] tx_q; // transmit shift register
  logic oe_q; // pulling the data line low
  logic [ADDR_W-1:0] addr_q; // address counter
  logic [see_pkg::FULL_ADDR_W-1:0] full_addr; // word address, widest form
  logic busy_q; // internal write cycle running
  logic [CW-1:0] twr_cnt_q; // clocks left in the write cycle

  see_mem_if #(.ADDR_W(ADDR_W), .PAGE_W(PAGE_W)) mif ();

  see_sync #(.WIDTH(3)) u_sync (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_d({i_wp, i_scl, i_sda}),
    .o_q(pins_s)
  );

  see_mem #(.ADDR_W(ADDR_W), .PAGE_W(PAGE_W)) u_mem (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .mif(mif.mem)
  );

  assign sda_s = pins_s[0];
  assign scl_s = pins_s[1];
  assign wp_s = pins_s[2];

  // previous line levels for edge and condition detection
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // conditions need the clock high on both samples
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;
  // bus interface is off during the write cycle
  assign bus_start = start_det & ~busy_q;
  assign bus_stop = stop_det & ~busy_q;
  assign byte_end = scl_fall & (bits_q == see_pkg::BYTE_BITS);

  assign type_ok = shreg_q[see_pkg::DTYPE_MSB:see_pkg::DTYPE_LSB]
    == DEV_TYPE;
  // wp blocks the data acknowledge, never the address ones
  assign ack_now = ((state_q == S_DEV) & type_ok)
    | (state_q == S_WADDR)
    | ((state_q == S_WDATA) & ~wp_s);
  assign wr_accept = (state_q == S_WDATA) & byte_end & ~wp_s;
  assign load_byte = scl_fall & (((state_q == S_ACK) & (ret_q == S_TX))
    | ((state_q == S_RACK) & mack_q));
  // unused variant bits drop off the top when the address counter loads
  assign full_addr = {dev_hi_q, shreg_q};

  // protocol sequencing
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= S_IDLE;
      ret_q <= S_IDLE;
    end else if (busy_q) begin
      state_q <= S_IDLE;
    end else if (bus_start) begin
      state_q <= S_DEV; // repeated start restarts too
    end else if (bus_stop) begin
      state_q <= S_IDLE;
    end else begin
      case (state_q)
        S_DEV: begin
          if (byte_end) begin
            if (type_ok) begin
              state_q <= S_ACK;
              ret_q <= (shreg_q[see_pkg::RW_BIT] == see_pkg::RW_READ)
                ? S_TX : S_WADDR;
            end else begin
              state_q <= S_IGNORE;
            end
          end
        end
        S_WADDR: begin
          if (byte_end) begin
            state_q <= S_ACK;
            ret_q <= S_WDATA;
          end
        end
        S_WDATA: begin
          if (byte_end) begin
            if (wp_s) begin
              state_q <= S_IGNORE;
            end else begin
              state_q <= S_ACK;
              ret_q <= S_WDATA;
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            state_q <= ret_q; // ninth clock over
          end
        end
        S_TX: begin
          if (byte_end) begin
            state_q <= S_RACK;
          end
        end
        S_RACK: begin
          if (scl_fall) begin
            state_q <= mack_q ? S_TX : S_IGNORE;
          end
        end
        default: begin
          // idle or ignoring: only a start or stop moves us
        end
      endcase
    end
  end

  // bit counter: receive counts rising edges, transmit falling ones
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      bits_q <= 4'h0;
    end else if (bus_start) begin
      bits_q <= 4'h0;
    end else if (load_byte) begin
      bits_q <= 4'h1; // first bit goes out with the load
    end else if (scl_rise && ((state_q == S_DEV) || (state_q == S_WADDR)
        || (state_q == S_WDATA))) begin
      bits_q <= bits_q + 4'h1;
    end else if (scl_fall && (state_q == S_ACK)) begin
      bits_q <= 4'h0;
    end else if (scl_fall && (state_q == S_TX) && !byte_end) begin
      bits_q <= bits_q + 4'h1;
    end
  end

  // receive shift register and the slave address fields
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      shreg_q <= 8'h00;
      dev_hi_q <= 3'h0;
    end else begin
      if (scl_rise && ((state_q == S_DEV) || (state_q == S_WADDR)
          || (state_q == S_WDATA))) begin
        shreg_q <= {shreg_q[6:0], sda_s};
      end
      if ((state_q == S_DEV) && byte_end && type_ok) begin
        dev_hi_q <= shreg_q[see_pkg::DHI_MSB:see_pkg::DHI_LSB];
      end
    end
  end

  // master acknowledge sampled on the ninth rising clock
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      mack_q <= 1'b0;
    end else if ((state_q == S_RACK) && scl_rise) begin
      mack_q <= ~sda_s;
    end else if (state_q != S_RACK) begin
      mack_q <= 1'b0;
    end
  end

  // data line drive: acknowledges and transmitted bits
  // sets only after a falling clock, so it never fakes a condition; start, stop and the write cycle release it at once
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      oe_q <= 1'b0;
      tx_q <= 8'h00;
    end else if (busy_q || bus_start || bus_stop) begin
      oe_q <= 1'b0;
    end else if (byte_end && ack_now) begin
      oe_q <= 1'b1;
    end else if (load_byte) begin
      oe_q <= ~mif.rdata[7];
      tx_q <= {mif.rdata[6:0], 1'b0};
    end else if (scl_fall && (state_q == S_ACK)) begin
      oe_q <= 1'b0; // release after the ninth clock
    end else if (scl_fall && (state_q == S_TX)) begin
      if (byte_end) begin
        oe_q <= 1'b0;
      end else begin
        oe_q <= ~tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // address counter; page writes keep the upper bits fixed
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      addr_q <= '0;
    end else if ((state_q == S_WADDR) && byte_end) begin
      addr_q <= full_addr[ADDR_W-1:0];
    end else if (wr_accept) begin
      addr_q <= {addr_q[ADDR_W-1:PAGE_W], addr_q[PAGE_W-1:0] + 4'h1};
    end else if ((state_q == S_TX) && byte_end) begin
      addr_q <= addr_q + 1'b1;
    end
  end

  // internal write cycle timer, started by the stop after data
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      busy_q <= 1'b0;
      twr_cnt_q <= '0;
    end else if (bus_stop && mif.pending) begin
      busy_q <= 1'b1;
      twr_cnt_q <= CW'(TWR_CYCLES - 1);
    end else if (busy_q) begin
      if (twr_cnt_q == '0) begin
        busy_q <= 1'b0;
      end else begin
        twr_cnt_q <= twr_cnt_q - 1'b1;
      end
    end
  end

  // memory side
  assign mif.raddr = addr_q;
  assign mif.buf_we = wr_accept;
  assign mif.buf_idx = addr_q[PAGE_W-1:0];
  assign mif.buf_data = shreg_q;
  assign mif.commit = bus_stop & mif.pending;
  assign mif.page = addr_q[ADDR_W-1:PAGE_W];

  assign o_sda_o = 1'b0; // open drain: only ever pulls low
  assign o_sda_oe = oe_q;
  assign o_busy = busy_q;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_resetn);

  property p_type_miss;
    (state_q == S_DEV) && byte_end && !type_ok && !busy_q
      |=> (state_q == S_IGNORE) && !o_sda_oe;
  endproperty
  a_type_miss: assert property (p_type_miss)
    else $error("foreign type code was not ignored");

  property p_addr_ack;
    (state_q == S_DEV) && byte_end && type_ok && !busy_q
      |=> o_sda_oe && (state_q == S_ACK);
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("own slave address not acknowledged");

  property p_ack_held;
    (state_q == S_ACK) |-> o_sda_oe;
  endproperty
  a_ack_held: assert property (p_ack_held)
    else $error("acknowledge released during ninth clock");

  property p_word_ack;
    (state_q == S_WADDR) && byte_end && !busy_q
      |=> (state_q == S_ACK) && (ret_q == S_WDATA);
  endproperty
  a_word_ack: assert property (p_word_ack)
    else $error("word address not acknowledged");

  property p_nack_stop;
    (state_q == S_RACK) && scl_fall && !mack_q && !start_det && !stop_det
      |=> (state_q == S_IGNORE) && !o_sda_oe;
  endproperty
  a_nack_stop: assert property (p_nack_stop)
    else $error("transmission went on after no acknowledge");

  property p_busy_deaf;
    busy_q |=> (state_q == S_IDLE) && !o_sda_oe;
  endproperty
  a_busy_deaf: assert property (p_busy_deaf)
    else $error("bus answered during write cycle");

  property p_page_inc;
    wr_accept && !start_det && !stop_det
      |=> (addr_q[PAGE_W-1:0] == 4'($past(addr_q[PAGE_W-1:0]) + 1))
        && $stable(addr_q[ADDR_W-1:PAGE_W]);
  endproperty
  a_page_inc: assert property (p_page_inc)
    else $error("page address step wrong");

  property p_wp_block;
    (state_q == S_WDATA) && byte_end && wp_s && !busy_q
      |=> !o_sda_oe ##1 !mif.pending || $past(mif.pending, 2);
  endproperty
  a_wp_block: assert property (p_wp_block)
    else $error("protected data byte accepted");

  property p_seq_inc;
    (state_q == S_TX) && byte_end && !busy_q
      |=> addr_q == ADDR_W'($past(addr_q) + 1'b1);
  endproperty
  a_seq_inc: assert property (p_seq_inc)
    else $error("read counter did not advance");

  property p_twr;
    bus_stop && mif.pending
      |=> busy_q && (twr_cnt_q == CW'(TWR_CYCLES - 1));
  endproperty
  a_twr: assert property (p_twr)
    else $error("write cycle not started at full length");

  property p_twr_end;
    busy_q && (twr_cnt_q == '0) |=> !busy_q;
  endproperty
  a_twr_end: assert property (p_twr_end)
    else $error("write cycle overran");

  property p_start;
    bus_start |=> (state_q == S_DEV) && (bits_q == 4'h0);
  endproperty
  a_start: assert property (p_start)
    else $error("start condition missed");

  c_read: cover property ((state_q == S_TX) ##1 (state_q == S_RACK));
  c_commit: cover property (bus_stop && mif.pending);
  c_wp: cover property ((state_q == S_WDATA) && byte_end && wp_s);
  c_poll: cover property (busy_q && start_det);
endmodule

// ### see_master.sv
// Purpose: bus master model that drives the bus clock and the data line
// Assumes: 200 ns bus clock, pull-up on the data line
// Notes: bus clock stands still high between frames
`timescale 1ns/100ps
module see_master (
  input wire logic i_sda,
  output logic o_scl,
  output logic o_pull
);
  // idle bus: clock high, data released
  initial begin
    o_scl = 1'b1;
    o_pull = 1'b0;
  end
  // start or repeated start; waits for the slave to let go first
  task automatic start();
    o_pull = 1'b0;
    #125 o_scl = 1'b1;
    #100 o_pull = 1'b1;
    #100 o_scl = 1'b0;
  endtask
  // stop: data rises while the clock is high
  task automatic stop();
    #25 o_pull = 1'b1;
    #105 o_scl = 1'b1;
    #100 o_pull = 1'b0;
    #100;
  endtask
  // long low phase lets the slave release before the next rise
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #25 o_pull = ~b[i];
      #105 o_scl = 1'b1;
      #70 o_scl = 1'b0;
    end
    #25 o_pull = 1'b0;
    #105 o_scl = 1'b1;
    #35 ack = ~i_sda;
    #35 o_scl = 1'b0;
  endtask
  // read one byte, then acknowledge it or not
  task automatic get_byte(input logic ack, output logic [7:0] b);
    o_pull = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #130 o_scl = 1'b1;
      #35 b[i] = i_sda;
      #35 o_scl = 1'b0;
    end
    #25 o_pull = ack;
    #105 o_scl = 1'b1;
    #70 o_scl = 1'b0;
    #25 o_pull = 1'b0;
  endtask
endmodule

// ### see_top_tb.sv
// Purpose: self-checking bench for the serial memory slave
// Assumes: 40 MHz system clock, bus master model on the far side
// Notes: write cycle shortened to keep the run brief
`timescale 1ns/100ps
module see_top_tb;
  localparam int unsigned TWR = 100; // short write cycle
  logic i_mclk, i_resetn, i_wp, scl, pull, sda_o, sda_oe, busy, sda;
  int error_cnt = 0;
  int n_compared = 0;
  logic [7:0] exp_mem [2048]; // expected array contents
  // open-drain wire with pull-up
  assign sda = (sda_oe ? sda_o : 1'b1) & ~pull;
  see_top #(.ADDR_W(11), .DEV_TYPE(see_pkg::DEV_TYPE_DEF),
    .TWR_CYCLES(TWR)) u_see_top (.i_mclk(i_mclk), .i_resetn(i_resetn),
    .i_scl(scl), .i_sda(sda), .i_wp(i_wp), .o_sda_o(sda_o),
    .o_sda_oe(sda_oe), .o_busy(busy));
  see_master u_see_master (.i_sda(sda), .o_scl(scl), .o_pull(pull));
  // system clock
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // start plus slave address; high address bits ride in it
  task automatic addr_ph(input logic [10:0] a, input logic rw,
    output logic ack);
    u_see_master.start();
    u_see_master.send_byte({see_pkg::DEV_TYPE_DEF, a[10:8], rw}, ack);
  endtask
  task automatic set_ptr(input logic [10:0] a);
    logic ack;
    addr_ph(a, 1'b0, ack);
    chk(11'(ack), 11'h1);
    u_see_master.send_byte(a[7:0], ack);
    chk(11'(ack), 11'h1);
  endtask
  // poll while busy, then wait the write cycle out
  task automatic wait_write();
    logic ack;
    int n;
    addr_ph(11'h0, 1'b0, ack);
    chk(11'(ack), 11'h0);
    chk(11'(busy), 11'h1);
    u_see_master.stop();
    n = 0;
    // look 2 ns past the edge, so the bus lines never move on an edge
    while (busy === 1'b1 && n < TWR + 2) begin
      @(posedge i_mclk);
      #2;
      n++;
    end
    chk(11'(busy), 11'h0);
    addr_ph(11'h0, 1'b0, ack);
    chk(11'(ack), 11'h1);
    u_see_master.stop();
  endtask
  // page write of n bytes; slot wraps in the page
  task automatic wbytes(input logic [10:0] a, input int n);
    logic [10:0] s;
    logic [7:0] d;
    logic ack;
    set_ptr(a);
    for (int i = 0; i < n; i++) begin
      s = {a[10:4], a[3:0] + 4'(i)};
      d = s[7:0] ^ 8'(i * 29);
      exp_mem[s] = d;
      u_see_master.send_byte(d, ack);
      chk(11'(ack), 11'h1);
    end
    u_see_master.stop();
    wait_write();
  endtask
  // random or current read of n bytes, nack on the last
  task automatic rdseq(input logic [10:0] a, input int n, input bit cur);
    logic ack;
    logic [7:0] b;
    if (!cur) set_ptr(a);
    addr_ph(a, 1'b1, ack);
    chk(11'(ack), 11'h1);
    for (int i = 0; i < n; i++) begin
      u_see_master.get_byte(i < n - 1, b);
      chk({3'h0, b}, {3'h0, exp_mem[11'(a + 11'(i))]});
    end
    u_see_master.stop();
  endtask
  task automatic t_byte();
    wbytes(11'h123, 1);
    rdseq(11'h123, 1, 1'b0);
    $display("byte write test done");
  endtask
  // eighteen bytes: the last two overwrite the first slots
  task automatic t_page();
    wbytes(11'h21e, 18);
    rdseq(11'h210, 16, 1'b0);
    $display("page write test done");
  endtask
  // protected: data refused, no cycle, array unchanged
  task automatic t_wp();
    logic ack;
    @(posedge i_mclk) #2 i_wp = 1'b1;
    set_ptr(11'h123);
    u_see_master.send_byte(8'h00, ack);
    chk(11'(ack), 11'h0);
    u_see_master.stop();
    repeat (8) @(posedge i_mclk);
    #2;
    chk(11'(busy), 11'h0);
    @(posedge i_mclk) #2 i_wp = 1'b0;
    rdseq(11'h123, 1, 1'b0);
    $display("write protect test done");
  endtask
  // every foreign type code is left unanswered
  task automatic t_type();
    logic ack;
    for (int c = 0; c < 16; c++) begin
      if (4'(c) != see_pkg::DEV_TYPE_DEF) begin
        u_see_master.start();
        u_see_master.send_byte({4'(c), 4'h0}, ack);
        chk(11'(ack), 11'h0);
        u_see_master.stop();
      end
    end
    $display("type code test done");
  endtask
  // top of the array: current read and sequential read wrap to 0
  task automatic t_wrap();
    wbytes(11'h7fe, 2);
    wbytes(11'h000, 1);
    rdseq(11'h7fe, 2, 1'b0);
    rdseq(11'h000, 1, 1'b1);
    rdseq(11'h7ff, 2, 1'b0);
    $display("wrap test done");
  endtask
  // main sequence
  initial begin
    i_resetn = 1'b0;
    i_wp = 1'b0;
    repeat (6) @(posedge i_mclk);
    #2 i_resetn = 1'b1;
    repeat (4) @(posedge i_mclk);
    // master model timing then stays clear of the sampling edges
    #2;
    t_byte();
    t_page();
    t_wp();
    t_type();
    t_wrap();
    report_and_stop();
  end
  // watchdog: the tests need well under a millisecond
  initial begin
    #2000000;
    error_cnt++;
    report_and_stop();
  end
endmodule
